// file: rtl/ltp_pkg.sv
// Constants shared by the link test pattern generator and its PRBS engine.
// Assumes an 8-bit register space reached through a parallel register port.
package ltp_pkg;

  // Register addresses.
  localparam logic [11:0] LTP_ADDR_CONFIG   = 12'h000;
  localparam logic [11:0] LTP_ADDR_USER_LO  = 12'h551;
  localparam logic [11:0] LTP_ADDR_USER_HI  = 12'h558;
  localparam logic [11:0] LTP_ADDR_LINKCFG  = 12'h571;
  localparam logic [11:0] LTP_ADDR_CONTROL  = 12'h573;

  // Soft reset request code and register reset values.
  localparam logic [7:0] LTP_SOFT_RESET_CODE = 8'h81;
  localparam logic [7:0] LTP_CONTROL_RESET   = 8'h00;
  localparam logic [7:0] LTP_LINKCFG_RESET   = 8'h00;
  localparam logic [7:0] LTP_USER_RESET      = 8'h00;

  // Field positions.
  localparam int LTP_SAMPLE_TEST_BIT = 5;
  localparam int LTP_MODE_LSB        = 0;
  localparam int LTP_MODE_MSB        = 3;
  localparam int LTP_POINT_LSB       = 4;
  localparam int LTP_POINT_MSB       = 5;

  // Pattern codes.
  localparam logic [3:0] LTP_MODE_OFF     = 4'h0;
  localparam logic [3:0] LTP_MODE_CHECKER = 4'h1;
  localparam logic [3:0] LTP_MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] LTP_MODE_PN31    = 4'h3;
  localparam logic [3:0] LTP_MODE_PRBS_TWENTYTHREE_BIT    = 4'h4;
  localparam logic [3:0] LTP_MODE_PN15    = 4'h5;
  localparam logic [3:0] LTP_MODE_PN9     = 4'h6;
  localparam logic [3:0] LTP_MODE_PN7     = 4'h7;
  localparam logic [3:0] LTP_MODE_RAMP    = 4'h8;
  localparam logic [3:0] LTP_MODE_REPEAT  = 4'hE;
  localparam logic [3:0] LTP_MODE_SINGLE  = 4'hF;

  // Injection point codes.
  localparam logic [1:0] LTP_POINT_SAMPLE = 2'h0;
  localparam logic [1:0] LTP_POINT_SYMBOL = 2'h1;
  localparam logic [1:0] LTP_POINT_OCTET  = 2'h2;

  // Word widths at each injection point.
  localparam logic [4:0] LTP_WIDTH_SAMPLE = 5'h10;
  localparam logic [4:0] LTP_WIDTH_SYMBOL = 5'h0A;
  localparam logic [4:0] LTP_WIDTH_OCTET  = 5'h08;

  // Checkerboard words.
  localparam logic [15:0] LTP_CHECK_EVEN = 16'h5555;
  localparam logic [15:0] LTP_CHECK_ODD  = 16'hAAAA;

  // PRBS seeds.
  localparam logic [30:0] LTP_SEED_PN31 = 31'h0003AFFF;
  localparam logic [30:0] LTP_SEED_PRBS_TWENTYTHREE_BIT = 31'h0000_3AFF;
  localparam logic [30:0] LTP_SEED_PN15 = 31'h0000_03AF;
  localparam logic [30:0] LTP_SEED_PN9  = 31'h0000_0092;
  localparam logic [30:0] LTP_SEED_PN7  = 31'h0000_0007;

endpackage : ltp_pkg

// file: rtl/ltp_prbs_gen.sv
// PRBS engine for the link test pattern generator: five polynomials.
// Assumes one clock; load and step are one-cycle pulses from the parent.
`timescale 1ns/10ps
module ltp_prbs_gen
  import ltp_pkg::*;
(
  input  wire logic        ref_clk,   // System clock.
  input  wire logic        rst_n,     // Asynchronous reset, active low.
  input  wire logic        loadSeed,  // Restart from the seed.
  input  wire logic        stepWord,  // Produce the next word.
  input  wire logic [3:0]  modeSel,   // Pattern code selecting polynomial.
  input  wire logic [4:0]  wordBits,  // Bits consumed per word.
  output logic      [15:0] prbsWord   // Latest word, low aligned.
);

  logic [30:0] stateReg;
  logic [30:0] stateNext;
  logic [15:0] wordNext;

  // Seed of the selected polynomial.
  function automatic logic [30:0] seedOf(input logic [3:0] m);
    unique case (m)
      LTP_MODE_PN31: seedOf = LTP_SEED_PN31;
      LTP_MODE_PRBS_TWENTYTHREE_BIT: seedOf = LTP_SEED_PRBS_TWENTYTHREE_BIT;
      LTP_MODE_PN15: seedOf = LTP_SEED_PN15;
      LTP_MODE_PN9:  seedOf = LTP_SEED_PN9;
      default:       seedOf = LTP_SEED_PN7;
    endcase
  endfunction : seedOf

  // Bit zero leaves first, so the seed goes out least significant bit
  // first; the feedback enters the top bit used by the polynomial.
  function automatic logic [30:0] stepOf(input logic [30:0] s,
                                         input logic [3:0]  m);
    stepOf = {1'b0, s[30:1]};
    unique case (m)
      LTP_MODE_PN31: stepOf[30] = s[0] ^ s[3];
      LTP_MODE_PRBS_TWENTYTHREE_BIT: stepOf[22] = s[0] ^ s[5];
      LTP_MODE_PN15: stepOf[14] = s[0] ^ s[1];
      LTP_MODE_PN9:  stepOf[8]  = s[0] ^ s[4];
      default:       stepOf[6]  = s[0] ^ s[1];
    endcase
  endfunction : stepOf

  // Serial stream packed most significant bit first into one word.
  always_comb begin
    stateNext = stateReg;
    wordNext  = '0;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < wordBits) begin
        wordNext  = {wordNext[14:0], stateNext[0]};
        stateNext = stepOf(stateNext, modeSel);
      end
    end
  end

  // State restarts from the seed on load; unused upper bits never feed back.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= LTP_SEED_PN7;
      prbsWord <= 16'h0000;
    end else if (loadSeed) begin
      stateReg <= seedOf(modeSel);
      prbsWord <= 16'h0000;
    end else if (stepWord) begin
      stateReg <= stateNext;
      prbsWord <= wordNext;
    end
  end

endmodule : ltp_prbs_gen

// file: rtl/ltp_link_test_pattern.sv
// Link test pattern generator: registers, pattern sources and injection.
// Assumes register accesses and link ticks are synchronous to ref_clk.
//
// What this block does
// - Reset code at address zero self-clears
// - Link config bit five enables sample test
// - Sample test sends raw converter samples
// - Control bits three-zero pick pattern; writing zero is ignored, only soft reset turns it off
// - Control bits five-four pick injection point
// - Code one: checkerboard 5555/AAAA, truncated
// - Code two: all-zeros/all-ones word toggle
// - Code three: PRBS31 from its seed
// - Code four: PRBS23 from its seed
// - Code five: PRBS15 from its seed
// - Code six: PRBS9 from its seed
// - Code seven: PRBS7 from its seed
// - Code eight: ramp wrapping at point width
// - User words come from eight byte registers
// - Code E repeats user words one-four
// - Code F sends user words once, then zeros
// - Sample point: whole frame one word
// - Symbol point: per symbol, user bits 15:6
// - Octet point: per octet, user bits 15:9
`timescale 1ns/10ps
module ltp_link_test_pattern
  import ltp_pkg::*;
(
  input  wire logic        ref_clk,      // 10 MHz system clock.
  input  wire logic        rst_n,        // Asynchronous reset, active low.
  input  wire logic [11:0] regAddr,      // Register address.
  input  wire logic [7:0]  regWrData,    // Register write data.
  input  wire logic        regWrEn,      // Register write strobe.
  input  wire logic        regRdEn,      // Register read strobe.
  output logic      [7:0]  regRdData,    // Read data, next cycle.
  input  wire logic [15:0] rawSample,    // Converter sample word.
  input  wire logic        frameTick,    // One pulse per frame.
  input  wire logic        symbolTick,   // One pulse per 10-bit symbol.
  input  wire logic        octetTick,    // One pulse per octet.
  output logic      [15:0] sampleOut,    // Word at the sample input.
  output logic             sampleInject, // Pattern replaces samples.
  output logic             sampleTest,   // Transport sample test on.
  output logic      [9:0]  symbolOut,    // Word at the symbol input.
  output logic             symbolInject, // Pattern replaces symbols.
  output logic      [7:0]  octetOut,     // Word at the octet input.
  output logic             octetInject,  // Pattern replaces octets.
  output logic             softReset     // One-cycle soft reset pulse.
);

  logic [7:0]  controlReg;
  logic [7:0]  linkCfgReg;
  logic [7:0]  userByteReg [8];
  logic [3:0]  activeModeReg;
  logic [1:0]  pointReg;
  logic        phaseReg;
  logic [15:0] rampReg;
  logic [1:0]  userIdxReg;
  logic        userDoneReg;
  logic        restartReg;
  logic [15:0] patWord;
  logic [15:0] prbsWord;
  logic [15:0] userWord;
  logic [4:0]  wordBits;
  logic        advance;
  logic        genOn;
  logic        ctlWrite;
  logic [3:0]  newMode;

  assign ctlWrite = regWrEn && (regAddr == LTP_ADDR_CONTROL);
  assign newMode  = regWrData[LTP_MODE_MSB:LTP_MODE_LSB];
  assign genOn    = (activeModeReg != LTP_MODE_OFF);

  // Soft reset fires on the reset code and clears itself next cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      softReset <= 1'b0;
    end else begin
      softReset <= regWrEn && (regAddr == LTP_ADDR_CONFIG) &&
                   (regWrData == LTP_SOFT_RESET_CODE);
    end
  end

  // Software-visible registers; soft reset returns them to defaults.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      controlReg <= LTP_CONTROL_RESET;
      linkCfgReg <= LTP_LINKCFG_RESET;
      for (int i = 0; i < 8; i++) userByteReg[i] <= LTP_USER_RESET;
    end else if (softReset) begin
      controlReg <= LTP_CONTROL_RESET;
      linkCfgReg <= LTP_LINKCFG_RESET;
      for (int i = 0; i < 8; i++) userByteReg[i] <= LTP_USER_RESET;
    end else if (regWrEn) begin
      if (regAddr == LTP_ADDR_CONTROL) controlReg <= regWrData;
      if (regAddr == LTP_ADDR_LINKCFG) linkCfgReg <= regWrData;
      if (regAddr >= LTP_ADDR_USER_LO && regAddr <= LTP_ADDR_USER_HI)
        userByteReg[3'(regAddr - LTP_ADDR_USER_LO)] <= regWrData;
    end
  end

  // Read data is registered; the configuration byte always reads zero
  // because the read mux has no entry for its address.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      if (regAddr == LTP_ADDR_CONTROL) regRdData <= controlReg;
      else if (regAddr == LTP_ADDR_LINKCFG) regRdData <= linkCfgReg;
      else if (regAddr >= LTP_ADDR_USER_LO && regAddr <= LTP_ADDR_USER_HI)
        regRdData <= userByteReg[3'(regAddr - LTP_ADDR_USER_LO)];
      else regRdData <= 8'h00;
    end
  end

  // The running pattern only changes on a nonzero code; writing zero
  // leaves it running until the soft reset, so software must reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      activeModeReg <= LTP_MODE_OFF;
      pointReg      <= LTP_POINT_SAMPLE;
      restartReg    <= 1'b0;
    end else if (softReset) begin
      activeModeReg <= LTP_MODE_OFF;
      pointReg      <= LTP_POINT_SAMPLE;
      restartReg    <= 1'b0;
    end else begin
      restartReg <= 1'b0;
      if (ctlWrite && newMode != LTP_MODE_OFF) begin
        activeModeReg <= newMode;
        pointReg      <= regWrData[LTP_POINT_MSB:LTP_POINT_LSB];
        restartReg    <= 1'b1;
      end
    end
  end

  // Advance strobe and word width follow the injection point.
  always_comb begin
    unique case (pointReg)
      LTP_POINT_SYMBOL: begin
        advance  = symbolTick;
        wordBits = LTP_WIDTH_SYMBOL;
      end
      LTP_POINT_OCTET: begin
        advance  = octetTick;
        wordBits = LTP_WIDTH_OCTET;
      end
      default: begin
        advance  = frameTick;
        wordBits = LTP_WIDTH_SAMPLE;
      end
    endcase
  end

  // Checkerboard and toggle phase; starts on the even word.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseReg <= 1'b0;
    end else if (restartReg) begin
      phaseReg <= 1'b0;
    end else if (advance) begin
      phaseReg <= ~phaseReg;
    end
  end

  // Ramp counts from zero and wraps at the point width via masking.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rampReg <= 16'h0000;
    end else if (restartReg) begin
      rampReg <= 16'h0000;
    end else if (advance) begin
      rampReg <= rampReg + 16'h0001;
    end
  end

  // User word index; single mode latches done after the fourth word.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      userIdxReg  <= 2'h0;
      userDoneReg <= 1'b0;
    end else if (restartReg) begin
      userIdxReg  <= 2'h0;
      userDoneReg <= 1'b0;
    end else if (advance) begin
      userIdxReg <= userIdxReg + 2'h1;
      if (userIdxReg == 2'h3 && activeModeReg == LTP_MODE_SINGLE)
        userDoneReg <= 1'b1;
    end
  end

  assign userWord = {userByteReg[{userIdxReg, 1'b1}],
                     userByteReg[{userIdxReg, 1'b0}]};

  ltp_prbs_gen u_prbs (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .loadSeed (restartReg),
    .stepWord (advance),
    .modeSel  (activeModeReg),
    .wordBits (wordBits),
    .prbsWord (prbsWord)
  );

  // Pattern word before truncation; user words keep their top bits.
  always_comb begin
    unique case (activeModeReg)
      LTP_MODE_CHECKER: patWord = phaseReg ? LTP_CHECK_ODD
                                           : LTP_CHECK_EVEN;
      LTP_MODE_TOGGLE:  patWord = {16{phaseReg}};
      LTP_MODE_PN31, LTP_MODE_PRBS_TWENTYTHREE_BIT, LTP_MODE_PN15,
      LTP_MODE_PN9, LTP_MODE_PN7:
                        patWord = prbsWord;
      LTP_MODE_RAMP:    patWord = rampReg;
      LTP_MODE_REPEAT:  patWord = userWord;
      LTP_MODE_SINGLE:  patWord = userDoneReg ? 16'h0000 : userWord;
      default:          patWord = 16'h0000;
    endcase
  end

  // Outputs are registered; one word serves every sample of a frame.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleOut    <= 16'h0000;
      symbolOut    <= 10'h000;
      octetOut     <= 8'h00;
      sampleInject <= 1'b0;
      symbolInject <= 1'b0;
      octetInject  <= 1'b0;
      sampleTest   <= 1'b0;
    end else begin
      sampleInject <= genOn && pointReg == LTP_POINT_SAMPLE;
      symbolInject <= genOn && pointReg == LTP_POINT_SYMBOL;
      octetInject  <= genOn && pointReg == LTP_POINT_OCTET;
      sampleTest   <= linkCfgReg[LTP_SAMPLE_TEST_BIT];
      if (genOn && pointReg == LTP_POINT_SAMPLE) sampleOut <= patWord;
      else sampleOut <= rawSample;
      if (activeModeReg == LTP_MODE_REPEAT ||
          activeModeReg == LTP_MODE_SINGLE) begin
        symbolOut <= patWord[15:6];
        octetOut  <= {1'b0, patWord[15:9]};
      end else begin
        symbolOut <= patWord[9:0];
        octetOut  <= patWord[7:0];
      end
    end
  end

  // Reset code yields exactly one soft reset pulse.
  property p_soft_pulse;
    @(posedge ref_clk) disable iff (!rst_n)
      (regWrEn && regAddr == LTP_ADDR_CONFIG &&
       regWrData == LTP_SOFT_RESET_CODE) |=> softReset ##1 !softReset;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse)
    else $error("soft reset pulse missing or stuck");

  // Writing zero keeps the running pattern until soft reset.
  property p_zero_keeps;
    @(posedge ref_clk) disable iff (!rst_n)
      (ctlWrite && newMode == LTP_MODE_OFF && genOn && !softReset)
      |=> genOn;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("pattern stopped without soft reset");

  // Soft reset stops generation.
  property p_soft_off;
    @(posedge ref_clk) disable iff (!rst_n)
      softReset |=> !genOn && controlReg == LTP_CONTROL_RESET;
  endproperty
  a_soft_off: assert property (p_soft_off)
    else $error("soft reset did not clear the mode");

  // Sample test flag follows link configuration bit five.
  property p_sample_test;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 sampleTest == $past(linkCfgReg[LTP_SAMPLE_TEST_BIT]);
  endproperty
  a_sample_test: assert property (p_sample_test)
    else $error("sample test flag wrong");

  // Without sample injection the raw sample passes through.
  property p_raw_pass;
    @(posedge ref_clk) disable iff (!rst_n)
      !(genOn && pointReg == LTP_POINT_SAMPLE) |=>
        sampleOut == $past(rawSample);
  endproperty
  a_raw_pass: assert property (p_raw_pass)
    else $error("raw sample not passed");

  // Checkerboard alternates between the two words on each advance.
  property p_checker;
    @(posedge ref_clk) disable iff (!rst_n)
      (activeModeReg == LTP_MODE_CHECKER && pointReg == LTP_POINT_SAMPLE
       && !restartReg && advance && !ctlWrite && !softReset)
      |=> ##1 sampleOut != $past(sampleOut);
  endproperty
  a_checker: assert property (p_checker)
    else $error("checkerboard did not alternate");

  // Mode entry restarts ramp, index and phase.
  property p_restart;
    @(posedge ref_clk) disable iff (!rst_n)
      restartReg && !softReset |=>
        rampReg == 16'h0000 && userIdxReg == 2'h0 && !phaseReg;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not clear generators");

  // Single user mode outputs zeros once done.
  property p_single_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      (activeModeReg == LTP_MODE_SINGLE && userDoneReg &&
       pointReg == LTP_POINT_SAMPLE) |=> sampleOut == 16'h0000;
  endproperty
  a_single_zero: assert property (p_single_zero)
    else $error("single user mode not zero after four words");

  // Toggle words at the sample point are all zeros or all ones.
  property p_toggle_word;
    @(posedge ref_clk) disable iff (!rst_n)
      (activeModeReg == LTP_MODE_TOGGLE && pointReg == LTP_POINT_SAMPLE)
      |=> (sampleOut == 16'h0000 || sampleOut == 16'hFFFF);
  endproperty
  a_toggle_word: assert property (p_toggle_word)
    else $error("toggle word not all zeros or all ones");

  // Checkerboard at the symbol point keeps only the low ten bits.
  property p_symbol_checker;
    @(posedge ref_clk) disable iff (!rst_n)
      activeModeReg == LTP_MODE_CHECKER |=>
        (symbolOut == 10'h155 || symbolOut == 10'h2AA);
  endproperty
  a_symbol_checker: assert property (p_symbol_checker)
    else $error("symbol checkerboard word wrong");

  // Each advance in ramp mode raises the count by exactly one.
  property p_ramp_step;
    @(posedge ref_clk) disable iff (!rst_n)
      (activeModeReg == LTP_MODE_RAMP && advance && !restartReg)
      |=> rampReg == $past(rampReg) + 16'h0001;
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("ramp did not step by one");

  // Repeat mode goes back to word one after word four.
  property p_user_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
      (activeModeReg == LTP_MODE_REPEAT && userIdxReg == 2'h3 && advance
       && !restartReg) |=> userIdxReg == 2'h0;
  endproperty
  a_user_wrap: assert property (p_user_wrap)
    else $error("repeat user pattern did not wrap");

endmodule : ltp_link_test_pattern

// file: bench/ltp_rx_model.sv
// Far-side receiver model: paces the link ticks and picks the lane word.
// Assumes the bench drives advance and stray just after a falling edge.
`timescale 1ns/10ps
module ltp_rx_model (
  input  wire logic [1:0]  pointSel,   // Injection point being received.
  input  wire logic        advance,    // Ask for the next word there.
  input  wire logic        stray,      // Pulse the other points instead.
  input  wire logic [15:0] sampleOut,  // Word at the sample input.
  input  wire logic [9:0]  symbolOut,  // Word at the symbol input.
  input  wire logic [7:0]  octetOut,   // Word at the octet input.
  output logic             frameTick,  // Frame pulse.
  output logic             symbolTick, // Symbol pulse.
  output logic             octetTick,  // Octet pulse.
  output logic      [15:0] rxWord      // Word seen by the receiver.
);
  // Stray pulses reach only the unused points, so a design that listens
  // to the wrong tick shows up as a skipped word.
  assign frameTick  = (pointSel == 2'h0) ? advance : stray;
  assign symbolTick = (pointSel == 2'h1) ? advance : stray;
  assign octetTick  = (pointSel == 2'h2) ? advance : stray;

  // The lane in use is zero extended, as a receiver would see it.
  assign rxWord = (pointSel == 2'h0) ? sampleOut :
                  (pointSel == 2'h1) ? {6'h00, symbolOut} :
                  {8'h00, octetOut};
endmodule : ltp_rx_model

// file: bench/tb_ltp_link_test_pattern.sv
// Self-checking bench for the link test pattern generator.
// Assumes the receiver model in ltp_rx_model and a 10 MHz ref_clk.
`timescale 1ns/10ps
module tb_ltp_link_test_pattern;
  import ltp_pkg::*;
  logic        ref_clk      = 1'b0;
  logic        rst_n        = 1'b0;
  logic [11:0] regAddr      = 12'h000;
  logic [7:0]  regWrData    = 8'h00;
  logic        regWrEn      = 1'b0;
  logic        regRdEn      = 1'b0;
  logic [15:0] rawSample    = 16'h0000;
  logic [1:0]  pointSel     = 2'h0;
  logic        advance      = 1'b0;
  logic        stray        = 1'b0;
  logic [7:0]  regRdData;
  logic        frameTick;
  logic        symbolTick;
  logic        octetTick;
  logic [15:0] sampleOut;
  logic [9:0]  symbolOut;
  logic [7:0]  octetOut;
  logic        sampleInject;
  logic        sampleTest;
  logic        symbolInject;
  logic        octetInject;
  logic        softReset;
  logic [15:0] rxWord;
  int          n_mismatch   = 0;
  int          checks       = 0;

  // Half period of 50 ns gives the 10 MHz clock.
  always #50 ref_clk = ~ref_clk;

  ltp_link_test_pattern i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .rawSample(rawSample),
    .frameTick(frameTick), .symbolTick(symbolTick),
    .octetTick(octetTick), .sampleOut(sampleOut),
    .sampleInject(sampleInject), .sampleTest(sampleTest),
    .symbolOut(symbolOut), .symbolInject(symbolInject),
    .octetOut(octetOut), .octetInject(octetInject),
    .softReset(softReset)
  );

  ltp_rx_model i_rx (
    .pointSel(pointSel), .advance(advance), .stray(stray),
    .sampleOut(sampleOut), .symbolOut(symbolOut), .octetOut(octetOut),
    .frameTick(frameTick), .symbolTick(symbolTick),
    .octetTick(octetTick), .rxWord(rxWord)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk

  // Each step ends just after a falling edge, where inputs may change.
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      @(negedge ref_clk);
    end
  endtask : cyc

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    cyc(1);
    regWrEn = 1'b0;
  endtask : wr

  // Read data is registered and holds, so one extra cycle is safe.
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    regAddr = a;
    regRdEn = 1'b1;
    cyc(1);
    regRdEn = 1'b0;
    cyc(1);
    chk("register read", {8'h00, exp}, {8'h00, regRdData});
  endtask : rd

  // One selected tick, then one stray cycle that must be ignored.
  task automatic adv();
    advance = 1'b1;
    cyc(1);
    advance = 1'b0;
    stray = 1'b1;
    cyc(1);
    stray = 1'b0;
  endtask : adv

  // Selects a mode and compares the word stream with the expected list.
  task automatic run(input string name, input logic [7:0] ctl,
                     input int n, input logic [15:0] e [6]);
    pointSel = ctl[5:4];
    wr(LTP_ADDR_CONTROL, ctl);
    cyc(2);
    chk("inject flags", {13'h0, 3'b100 >> ctl[5:4]},
        {13'h0, sampleInject, symbolInject, octetInject});
    chk(name, e[0], rxWord);
    for (int i = 1; i < n; i++) begin
      adv();
      chk(name, e[i], rxWord);
    end
    $display("done %s", name);
  endtask : run

  task automatic t_reset();
    logic [7:0] ub [8];
    ub = '{8'hC3, 8'hA5, 8'h34, 8'h12, 8'hDC, 8'hFE, 8'h0F, 8'h0F};
    rawSample = 16'h1357;
    cyc(2);
    chk("normal sample", 16'h1357, sampleOut);
    rd(LTP_ADDR_CONTROL, 8'h00);
    rd(LTP_ADDR_LINKCFG, 8'h00);
    wr(12'h7FF, 8'h5A);
    rd(12'h7FF, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(LTP_ADDR_USER_LO + 12'(k), ub[k]);
      cyc(1);
    end
    rd(12'h552, 8'hA5);
    $display("done reset and registers");
  endtask : t_reset

  // The first word of each remaining sequence follows from its seed,
  // sent least significant bit first, and from its polynomial.
  task automatic t_prbs_rest();
    logic [15:0] a;
    logic [15:0] f [3];
    f = '{16'hFFF5, 16'hF5C0, 16'hE041};
    for (int c = 3; c <= 7; c += 2) begin
      pointSel = 2'h0;
      wr(LTP_ADDR_CONTROL, 8'(c));
      cyc(2);
      adv();
      a = rxWord;
      chk("prbs first", f[(c - 3) / 2], a);
      adv();
      chk("prbs moves", 16'h1, 16'(a != 16'h0 && a !== rxWord));
    end
    $display("done other prbs");
  endtask : t_prbs_rest

  task automatic t_wrap();
    pointSel = 2'h2;
    wr(LTP_ADDR_CONTROL, 8'h28);
    cyc(2);
    repeat (255) adv();
    chk("ramp top", 16'h00FF, rxWord);
    adv();
    chk("ramp wrap", 16'h0000, rxWord);
    $display("done ramp wrap");
  endtask : t_wrap

  task automatic t_soft();
    int p;
    p = 0;
    wr(LTP_ADDR_CONTROL, 8'h00);
    rd(LTP_ADDR_CONTROL, 8'h00);
    chk("held pattern", 16'h1, {15'h0, octetInject});
    wr(LTP_ADDR_CONFIG, LTP_SOFT_RESET_CODE);
    repeat (3) begin
      p += int'(softReset);
      cyc(1);
    end
    chk("soft pulses", 16'h1, 16'(p));
    chk("inject off", 16'h0,
        {13'h0, sampleInject, symbolInject, octetInject});
    rd(LTP_ADDR_CONFIG, 8'h00);
    rd(LTP_ADDR_USER_LO, 8'h00);
    $display("done soft reset");
  endtask : t_soft

  task automatic t_sample_test();
    wr(LTP_ADDR_LINKCFG, 8'h20);
    rawSample = 16'hBEEF;
    cyc(2);
    chk("sample test", 16'h1, {15'h0, sampleTest});
    chk("raw samples", 16'hBEEF, sampleOut);
    rd(LTP_ADDR_LINKCFG, 8'h20);
    $display("done sample test");
  endtask : t_sample_test

  // The run takes under two thousand cycles; ten thousand is the limit.
  initial begin
    #1000000;
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    cyc(1);
    t_reset();
    run("chk16", 8'h01, 3, '{16'h5555, 16'hAAAA, 16'h5555, 0, 0, 0});
    run("tgl16", 8'h02, 3, '{16'h0, 16'hFFFF, 16'h0, 0, 0, 0});
    run("ramp16", 8'h08, 4, '{16'h0, 16'h1, 16'h2, 16'h3, 0, 0});
    run("pn9s", 8'h06, 6, '{16'h0, 16'h496F, 16'hC9A9, 16'h980C,
        16'h651A, 16'h5FD1});
    run("pn23s", 8'h04, 5, '{16'h0, 16'hFF5C, 16'h0029, 16'hB80A,
        16'h3D72, 0});
    run("rep16", 8'h0E, 5, '{16'hA5C3, 16'h1234, 16'hFEDC, 16'h0F0F,
        16'hA5C3, 0});
    run("sgl16", 8'h0F, 6, '{16'hA5C3, 16'h1234, 16'hFEDC, 16'h0F0F,
        0, 0});
    run("chk10", 8'h11, 3, '{16'h155, 16'h2AA, 16'h155, 0, 0, 0});
    run("pn9y", 8'h16, 5, '{16'h0, 16'h125, 16'h2FC, 16'h26A,
        16'h198, 0});
    run("pn23y", 8'h14, 5, '{16'h0, 16'h3FD, 16'h1C0, 16'h00A,
        16'h1B8, 0});
    run("sgl10", 8'h1F, 6, '{16'h297, 16'h048, 16'h3FB, 16'h03C,
        0, 0});
    run("tgl8", 8'h22, 3, '{16'h0, 16'hFF, 16'h0, 0, 0, 0});
    run("pn9o", 8'h26, 5, '{16'h0, 16'h49, 16'h6F, 16'hC9,
        16'hA9, 0});
    run("pn23o", 8'h24, 5, '{16'h0, 16'hFF, 16'h5C, 16'h00,
        16'h29, 0});
    run("rep8", 8'h2E, 5, '{16'h52, 16'h09, 16'h7F, 16'h07,
        16'h52, 0});
    t_prbs_rest();
    t_wrap();
    t_soft();
    t_sample_test();
    test_done();
  end
endmodule : tb_ltp_link_test_pattern
